// file: design/prefix_byte_decode.sv
// prefix register, operand decode and general byte register of the core
`timescale 1ns/1ps

// Notes on behaviour
// (RL1) one fixed 16-bit instruction completes per clock; prefixed ops take two
// (RL2) prefix value lasts one cycle then clears to zero by itself
// (RL3) immediate upper byte comes from prior prefix, else zero
// (RL4) branch is absolute only when prefix was written the cycle before
// (RL5) unprefixed reach: destination index to 07h, source index to 0Fh
// (RL6) operands are direct registers, pointer-indirect memory, or immediates
// (RL7) direct addressing can target a single bit of a register
// (RL8) indirect operand address is the pointer register contents
// (RL9) stack pop returns word at stack pointer then decrements it
// (RL10) general byte register readable and writable whole or per byte
// (RL11) swapped view returns general register with bytes exchanged
// (RL12) sign-extended view replicates low byte bit 7 into upper byte
// (RL13) 8-bit source to 16-bit destination takes upper byte from prefix
// (RL14) unprefixed 8-bit to 16-bit move writes zero upper byte
// (RL15) 16-bit source to 8-bit destination keeps only the low byte
// (RL16) prefix write holds off a pending interrupt for one cycle
// (RL17) bit op on unsupporting register writes prefix high, mask low
// (RL18) prefix variant records extra destination and source index bits
module prefix_byte_decode
(
	input  wire logic                            clk_sys,
	input  wire logic                            rst,
	input  wire logic                            instr_valid,
	input  wire logic [15:0]                     instr,
	input  wire logic [15:0]                     ext_src_data,
	input  wire logic                            ext_src_wide,
	input  wire logic                            ext_dst_wide,
	input  wire logic [15:0]                     mem_rd_data,
	input  wire logic                            irq_pending,
	output logic                                 irq_grant,
	output logic                                 prefix_active,
	output logic [7:0]                           prefix_data,
	output logic                                 src_index_hi,
	output prefix_decode_pkg::reg_write_t        reg_wr,
	output prefix_decode_pkg::mem_write_t        mem_wr,
	output prefix_decode_pkg::branch_t           branch,
	output logic [15:0]                          general_byte_register,
	output logic [15:0]                          data_pointer_reg,
	output logic [15:0]                          stack_pointer_reg
);
	import prefix_decode_pkg::*;

	prefix_state_t prefix_state;
	logic [1:0]    dst_index_hi;

	// -----------------------------------------------------------------
	// field decode
	// -----------------------------------------------------------------
	wire        reg_src    = instr[SRC_FORM_BIT];
	wire [2:0]  dst_lo     = instr[DST_IDX_MSB:DST_IDX_LSB];
	wire [3:0]  dst_mod    = instr[DST_MOD_MSB:DST_MOD_LSB];
	wire [7:0]  imm_byte   = instr[SRC_IDX_MSB:SRC_MOD_LSB];
	wire [3:0]  src_lo     = instr[SRC_IDX_MSB:SRC_IDX_LSB];
	wire [3:0]  src_mod    = instr[SRC_MOD_MSB:SRC_MOD_LSB];
	wire [4:0]  dst_idx    = {dst_index_hi, dst_lo}; // RL5 RL18
	wire [4:0]  src_idx    = {src_index_hi, src_lo}; // RL5 RL18
	wire        held       = (prefix_state == PREFIX_HELD);

	wire        src_sys    = reg_src && (src_mod == MOD_SYS);
	wire        src_ind    = reg_src && (src_mod == MOD_INDIR); // RL6
	wire        pop_now    = instr_valid && src_ind
	                         && (src_idx == IDX_POP); // RL9

	wire        prefix_wr  = instr_valid && (dst_mod == MOD_PREFIX);
	wire        sys_wr     = instr_valid && (dst_mod == MOD_SYS);
	wire        ind_wr     = instr_valid && (dst_mod == MOD_INDIR)
	                         && (dst_idx == IDX_AT_DATA); // RL8
	wire        bit_now    = instr_valid && (dst_mod == MOD_BITOP)
	                         && !reg_src; // RL7
	wire        br_now     = instr_valid && (dst_mod == MOD_BRANCH);
	wire        ext_wr_now = instr_valid && !prefix_wr && !sys_wr
	                         && (dst_mod != MOD_INDIR) && !bit_now
	                         && (dst_mod != MOD_BITOP) && !br_now;

	// -----------------------------------------------------------------
	// general byte register views
	// -----------------------------------------------------------------
	wire [15:0] gv_upper   = {8'h00, general_byte_register[15:8]}; // RL10
	wire [15:0] gv_lower   = {8'h00, general_byte_register[7:0]}; // RL10
	wire [15:0] gv_swapped = {general_byte_register[7:0],
	                          general_byte_register[15:8]}; // RL11
	wire [15:0] gv_signext = {{8{general_byte_register[7]}},
	                          general_byte_register[7:0]}; // RL12

	wire [15:0] sys_val =
		(src_idx == IDX_GENERAL)  ? general_byte_register :
		(src_idx == IDX_UPPER)    ? gv_upper :
		(src_idx == IDX_LOWER)    ? gv_lower :
		(src_idx == IDX_SWAPPED)  ? gv_swapped :
		(src_idx == IDX_SIGNEXT)  ? gv_signext :
		(src_idx == IDX_DATAPTR)  ? data_pointer_reg :
		(src_idx == IDX_STACKPTR) ? stack_pointer_reg : 16'h0000;
	wire        sys_src_wide = (src_idx != IDX_UPPER)
	                           && (src_idx != IDX_LOWER);
	wire        sys_dst_wide = (dst_idx != IDX_UPPER)
	                           && (dst_idx != IDX_LOWER);

	// -----------------------------------------------------------------
	// operand select and width conversion
	// -----------------------------------------------------------------
	wire [15:0] src_val  = !reg_src ? {8'h00, imm_byte} :
	                       src_ind  ? mem_rd_data :
	                       src_sys  ? sys_val : ext_src_data; // RL6 RL8
	wire        src_wide = reg_src && (src_ind || (src_sys ? sys_src_wide
	                       : ext_src_wide));
	wire        dst_wide = sys_wr ? sys_dst_wide :
	                       (dst_mod == MOD_INDIR) ? 1'b1 : ext_dst_wide;
	// narrow source into wide target picks up the prefix byte
	wire [15:0] move_val = !dst_wide ? {8'h00, src_val[7:0]} : // RL15
	                       src_wide  ? src_val :
	                       {prefix_data, src_val[7:0]}; // RL3 RL13 RL14

	// -----------------------------------------------------------------
	// bit set / clear
	// -----------------------------------------------------------------
	wire        bit_set  = imm_byte[BITOP_SET_BIT];
	wire [7:0]  bit_one  = 8'h01 << dst_lo;
	wire [7:0]  bit_mask = bit_set ? bit_one : ~bit_one;
	wire [3:0]  bit_mod  = imm_byte[SRC_MOD_MSB:SRC_MOD_LSB];
	wire [4:0]  bit_idx  = {dst_index_hi, imm_byte[6:4]};
	wire        bit_gen  = bit_now && (bit_mod == MOD_SYS)
	                       && ((bit_idx == IDX_GENERAL)
	                       || (bit_idx == IDX_LOWER));
	wire [7:0]  bit_low  = bit_set ? (general_byte_register[7:0] | bit_one)
	                       : (general_byte_register[7:0] & bit_mask);

	// -----------------------------------------------------------------
	// next values
	// -----------------------------------------------------------------
	wire [15:0] next_general =
		bit_gen ? {general_byte_register[15:8], bit_low} : // RL7
		!sys_wr ? general_byte_register :
		(dst_idx == IDX_GENERAL) ? move_val :
		(dst_idx == IDX_UPPER) ? {move_val[7:0],
		                          general_byte_register[7:0]} :
		(dst_idx == IDX_LOWER) ? {general_byte_register[15:8],
		                          move_val[7:0]} :
		general_byte_register; // RL10
	wire        dp_wr      = sys_wr && (dst_idx == IDX_DATAPTR);
	wire        sp_wr      = sys_wr && (dst_idx == IDX_STACKPTR);
	wire [15:0] next_sp    = sp_wr ? move_val :
	                         pop_now ? (stack_pointer_reg - 16'h0001) :
	                         stack_pointer_reg; // RL9

	reg_write_t next_reg_wr;
	assign next_reg_wr.en     = ext_wr_now || (bit_now && !bit_gen);
	assign next_reg_wr.mod    = bit_now ? bit_mod : dst_mod;
	assign next_reg_wr.index  = bit_now ? bit_idx : dst_idx;
	assign next_reg_wr.data   = bit_now ? {prefix_data, bit_mask}
	                            : move_val; // RL17
	assign next_reg_wr.bit_op = bit_now;
	assign next_reg_wr.mask   = bit_now ? bit_mask : 8'h00;

	mem_write_t next_mem_wr;
	assign next_mem_wr.en   = ind_wr;
	assign next_mem_wr.addr = data_pointer_reg; // RL8
	assign next_mem_wr.data = move_val;

	branch_t next_branch;
	assign next_branch.en       = br_now;
	assign next_branch.absolute = held; // RL4
	assign next_branch.value    = held ? {prefix_data, src_val[7:0]}
	                              : {{8{src_val[7]}}, src_val[7:0]};

	// -----------------------------------------------------------------
	// prefix holding register
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			prefix_state <= PREFIX_IDLE;
			prefix_data  <= PREFIX_RESET;
			dst_index_hi <= 2'b00;
			src_index_hi <= 1'b0;
		end
		else
		begin
			case (prefix_state)
				PREFIX_IDLE, PREFIX_HELD:
				begin
					// value survives exactly one cycle
					prefix_state <= prefix_wr ? PREFIX_HELD : PREFIX_IDLE; // RL2
					prefix_data  <= prefix_wr ? src_val[7:0] : PREFIX_RESET; // RL2
					dst_index_hi <= prefix_wr ? dst_lo[1:0] : 2'b00; // RL18
					src_index_hi <= prefix_wr ? dst_lo[2] : 1'b0; // RL18
				end
				default:
				begin
					prefix_state <= PREFIX_IDLE;
					prefix_data  <= PREFIX_RESET;
					dst_index_hi <= 2'b00;
					src_index_hi <= 1'b0;
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// architectural state and registered outputs
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			general_byte_register <= GENERAL_RESET;
			data_pointer_reg      <= DATAPTR_RESET;
			stack_pointer_reg     <= STACKPTR_RESET;
			reg_wr                <= '0;
			mem_wr                <= '0;
			branch                <= '0;
			irq_grant             <= 1'b0;
		end
		else
		begin
			general_byte_register <= next_general; // RL1
			data_pointer_reg      <= dp_wr ? move_val : data_pointer_reg;
			stack_pointer_reg     <= next_sp;
			reg_wr                <= next_reg_wr;
			mem_wr                <= next_mem_wr;
			branch                <= next_branch;
			irq_grant             <= irq_pending && !prefix_wr; // RL16
		end
	end

	assign prefix_active = held;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_prefix_one_cycle: assert property ( // RL2
		!prefix_wr |=> !held && prefix_data == 8'h00
			&& dst_index_hi == 2'b00 && !src_index_hi)
		else $error("prefix value outlived its cycle");
	a_prefix_loads_value: assert property ( // RL2
		prefix_wr |=> held && prefix_data == $past(src_val[7:0]))
		else $error("prefix write not held");
	a_imm_upper_byte: assert property ( // RL3
		ext_wr_now && !reg_src && ext_dst_wide
		|=> reg_wr.en && reg_wr.data[15:8] == $past(prefix_data))
		else $error("immediate upper byte not from prefix");
	a_branch_kind: assert property ( // RL4
		br_now |=> branch.en && branch.absolute == $past(held))
		else $error("branch kind does not follow prefix");
	a_unprefixed_reach: assert property ( // RL5
		ext_wr_now && !held |=> reg_wr.index <= 5'h07)
		else $error("unprefixed destination beyond 07h");
	a_pop_decrement: assert property ( // RL9
		pop_now && !sp_wr ##1 1'b1
		|-> stack_pointer_reg == $past(stack_pointer_reg) - 16'h0001)
		else $error("pop did not decrement stack pointer");
	a_swap_view: assert property ( // RL11
		sys_wr && dst_idx == IDX_GENERAL && src_sys
		&& src_idx == IDX_SWAPPED
		|=> general_byte_register[7:0] == $past(general_byte_register[15:8])
		&& general_byte_register[15:8] == $past(general_byte_register[7:0]))
		else $error("swapped view wrong");
	a_narrow_store: assert property ( // RL15
		ext_wr_now && src_wide && !ext_dst_wide
		|=> reg_wr.data == {8'h00, $past(src_val[7:0])})
		else $error("wide to narrow move kept upper byte");
	a_irq_deferred: assert property ( // RL16
		prefix_wr |=> !irq_grant)
		else $error("interrupt granted in prefix window");
	a_bit_op_data: assert property ( // RL17
		bit_now && !bit_gen |=> reg_wr.bit_op
		&& reg_wr.data[15:8] == $past(prefix_data))
		else $error("bit op upper byte not prefix");
endmodule

// file: design/prefix_decode_pkg.sv
// shared constants and types for the prefix and byte transfer decoder
package prefix_decode_pkg;

	// -----------------------------------------------------------------
	// instruction fields
	// -----------------------------------------------------------------
	localparam int unsigned INSTR_W       = 16;
	localparam int unsigned SRC_FORM_BIT  = 15;
	localparam int unsigned DST_IDX_MSB   = 14;
	localparam int unsigned DST_IDX_LSB   = 12;
	localparam int unsigned DST_MOD_MSB   = 11;
	localparam int unsigned DST_MOD_LSB   = 8;
	localparam int unsigned SRC_IDX_MSB   = 7;
	localparam int unsigned SRC_IDX_LSB   = 4;
	localparam int unsigned SRC_MOD_MSB   = 3;
	localparam int unsigned SRC_MOD_LSB   = 0;
	localparam int unsigned BITOP_SET_BIT = 7;

	// -----------------------------------------------------------------
	// module numbers and sub-indexes
	// -----------------------------------------------------------------
	localparam logic [3:0] MOD_BITOP  = 4'h9;
	localparam logic [3:0] MOD_INDIR  = 4'hA;
	localparam logic [3:0] MOD_PREFIX = 4'hB;
	localparam logic [3:0] MOD_SYS    = 4'hC;
	localparam logic [3:0] MOD_BRANCH = 4'hF;

	localparam logic [4:0] IDX_GENERAL  = 5'h00;
	localparam logic [4:0] IDX_UPPER    = 5'h01;
	localparam logic [4:0] IDX_LOWER    = 5'h02;
	localparam logic [4:0] IDX_SWAPPED  = 5'h03;
	localparam logic [4:0] IDX_SIGNEXT  = 5'h04;
	localparam logic [4:0] IDX_DATAPTR  = 5'h05;
	localparam logic [4:0] IDX_STACKPTR = 5'h06;
	localparam logic [4:0] IDX_AT_DATA  = 5'h00;
	localparam logic [4:0] IDX_POP      = 5'h01;

	// -----------------------------------------------------------------
	// reset values
	// -----------------------------------------------------------------
	localparam logic [7:0]  PREFIX_RESET   = 8'h00;
	localparam logic [15:0] GENERAL_RESET  = 16'h0000;
	localparam logic [15:0] DATAPTR_RESET  = 16'h0000;
	localparam logic [15:0] STACKPTR_RESET = 16'h0000;

	typedef enum logic [0:0] {
		PREFIX_IDLE = 1'b0,
		PREFIX_HELD = 1'b1
	} prefix_state_t;

	typedef struct packed {
		logic        en;
		logic [3:0]  mod;
		logic [4:0]  index;
		logic [15:0] data;
		logic        bit_op;
		logic [7:0]  mask;
	} reg_write_t;

	typedef struct packed {
		logic        en;
		logic [15:0] addr;
		logic [15:0] data;
	} mem_write_t;

	typedef struct packed {
		logic        en;
		logic        absolute;
		logic [15:0] value;
	} branch_t;

endpackage

// file: tb/tb_top.sv
// self-checking bench for the prefix and byte transfer decoder
`timescale 1ns/1ps
module tb_top;
	import prefix_decode_pkg::*;

	// -----------------------------------------------------------------
	// signals
	// -----------------------------------------------------------------
	logic        clk_sys = 1'b0;
	logic        rst, instr_valid, ext_src_wide, ext_dst_wide, irq_pending;
	logic [15:0] instr, ext_src_data, mem_rd_data;
	logic        irq_grant, prefix_active, src_index_hi, s;
	logic [7:0]  prefix_data, hi, lo, b, c;
	reg_write_t  reg_wr;
	mem_write_t  mem_wr;
	branch_t     branch;
	logic [15:0] general_byte_register, data_pointer_reg, stack_pointer_reg;
	logic [15:0] g;
	logic [2:0]  n, sub;
	int          n_fail = 0;
	int          n_compared = 0;
	integer      seed = 7054;

	prefix_byte_decode dut
	(
		.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid),
		.instr(instr), .ext_src_data(ext_src_data),
		.ext_src_wide(ext_src_wide), .ext_dst_wide(ext_dst_wide),
		.mem_rd_data(mem_rd_data), .irq_pending(irq_pending),
		.irq_grant(irq_grant), .prefix_active(prefix_active),
		.prefix_data(prefix_data), .src_index_hi(src_index_hi),
		.reg_wr(reg_wr), .mem_wr(mem_wr), .branch(branch),
		.general_byte_register(general_byte_register),
		.data_pointer_reg(data_pointer_reg),
		.stack_pointer_reg(stack_pointer_reg)
	);

	always #10 clk_sys = ~clk_sys;

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	// drive at a falling edge, return one cycle later with results settled
	task automatic ex(input logic [15:0] i);
		instr_valid = 1'b1;
		instr = i;
		@(negedge clk_sys);
	endtask

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] got);
		n_compared++;
		n_fail += (got !== e);
		if (got !== e) $display("wrong value %s expected %h seen %h", nm, e, got);
	endtask

	function automatic logic [15:0] imm(input logic [3:0] m,
		input logic [2:0] d, input logic [7:0] v);
		return {1'b0, d, m, v};
	endfunction

	function automatic logic [15:0] rs(input logic [3:0] m,
		input logic [2:0] d, input logic [3:0] ss, input logic [3:0] sm);
		return {1'b1, d, m, ss, sm};
	endfunction

	function automatic logic [15:0] sx(input logic [7:0] v);
		return {{8{v[7]}}, v};
	endfunction

	function automatic logic [7:0] bm(input logic [2:0] k, input logic st);
		return st ? (8'h01 << k) : ~(8'h01 << k);
	endfunction

	// -----------------------------------------------------------------
	// tests
	// -----------------------------------------------------------------
	task automatic t_prefix;
		irq_pending = 1'b1;
		ex(imm(MOD_PREFIX, n, hi));
		chk("prefix_active", 16'h0001, prefix_active);
		chk("prefix_data", {8'h00, hi}, prefix_data);
		chk("src_index_hi", {15'h0000, n[2]}, src_index_hi);
		chk("irq_grant", 16'h0000, irq_grant);
		ex(imm(4'h1, sub, lo));
		chk("reg_wr.data", {hi, lo}, reg_wr.data);
		chk("reg_wr.index", {11'h000, n[1:0], sub}, reg_wr.index);
		chk("prefix_data", 16'h0000, prefix_data);
		chk("irq_grant", 16'h0001, irq_grant);
		irq_pending = 1'b0;
		ex(imm(4'h1, sub, lo));
		chk("reg_wr.data", {8'h00, lo}, reg_wr.data);
		chk("reg_wr.index", {13'h0000, sub}, reg_wr.index);
		instr_valid = 1'b0;
		@(negedge clk_sys);
		chk("reg_wr.en", 16'h0000, reg_wr.en);
		$display("prefix test done");
	endtask

	task automatic t_sizes;
		ext_src_data = 16'($random(seed));
		ext_src_wide = 1'b0;
		ex(imm(MOD_PREFIX, 3'h0, hi));
		ex(rs(4'h2, sub, 4'h7, 4'h1));
		chk("reg_wr.data", {hi, ext_src_data[7:0]}, reg_wr.data);
		ex(rs(4'h2, sub, 4'h7, 4'h1));
		chk("reg_wr.data", {8'h00, ext_src_data[7:0]}, reg_wr.data);
		ext_src_wide = 1'b1;
		ext_dst_wide = 1'b0;
		ex(rs(4'h2, sub, 4'hF, 4'h1));
		chk("reg_wr.data", {8'h00, ext_src_data[7:0]}, reg_wr.data);
		ext_dst_wide = 1'b1;
		$display("size test done");
	endtask

	task automatic t_branch;
		ex(imm(MOD_BRANCH, 3'h0, lo));
		chk("branch.en", 16'h0001, branch.en);
		chk("branch.absolute", 16'h0000, branch.absolute);
		chk("branch.value", sx(lo), branch.value);
		ex(imm(MOD_PREFIX, 3'h0, 8'h00));
		chk("branch.en", 16'h0000, branch.en);
		ex(imm(MOD_BRANCH, 3'h0, lo));
		chk("branch.absolute", 16'h0001, branch.absolute);
		chk("branch.value", {8'h00, lo}, branch.value);
		$display("branch test done");
	endtask

	task automatic t_general;
		ex(imm(MOD_PREFIX, 3'h0, hi));
		ex(imm(MOD_SYS, 3'h0, lo));
		chk("general", {hi, lo}, general_byte_register);
		ex(imm(MOD_SYS, 3'h1, b));
		ex(imm(MOD_SYS, 3'h2, c));
		chk("general", {b, c}, general_byte_register);
		ex(imm(MOD_SYS, 3'h3, lo));
		ex(imm(MOD_SYS, 3'h4, hi));
		chk("general", {b, c}, general_byte_register);
		ex(rs(4'h1, 3'h0, 4'h3, MOD_SYS));
		chk("swapped view", {c, b}, reg_wr.data);
		ex(rs(4'h1, 3'h0, 4'h4, MOD_SYS));
		chk("sign view", sx(c), reg_wr.data);
		ex(rs(4'h1, 3'h0, 4'h1, MOD_SYS));
		chk("upper view", {8'h00, b}, reg_wr.data);
		ex(rs(MOD_SYS, 3'h0, 4'h3, MOD_SYS));
		chk("general", {c, b}, general_byte_register);
		g = {c, b};
		$display("general test done");
	endtask

	task automatic t_bitop;
		ex(imm(MOD_PREFIX, 3'h0, hi));
		ex({1'b0, n, MOD_BITOP, s, sub, 4'h1});
		chk("reg_wr.bit_op", 16'h0001, reg_wr.bit_op);
		chk("reg_wr.data", {hi, bm(n, s)}, reg_wr.data);
		chk("reg_wr.mask", {8'h00, bm(n, s)}, reg_wr.mask);
		chk("reg_wr.index", {13'h0000, sub}, reg_wr.index);
		chk("reg_wr.mod", 16'h0001, reg_wr.mod);
		ex({1'b0, n, MOD_BITOP, s, 3'h0, MOD_SYS});
		g[n] = s;
		chk("general", g, general_byte_register);
		$display("bit test done");
	endtask

	task automatic t_pointer;
		ex(imm(MOD_PREFIX, 3'h0, hi));
		ex(imm(MOD_SYS, 3'h5, lo));
		chk("data_pointer_reg", {hi, lo}, data_pointer_reg);
		ex(imm(MOD_INDIR, 3'h0, b));
		chk("mem_wr.addr", {hi, lo}, mem_wr.addr);
		chk("mem_wr.data", {8'h00, b}, mem_wr.data);
		chk("mem_wr.en", 16'h0001, mem_wr.en);
		mem_rd_data = 16'($random(seed));
		ex(rs(4'h1, 3'h0, 4'h0, MOD_INDIR));
		chk("reg_wr.data", mem_rd_data, reg_wr.data);
		ex(imm(MOD_PREFIX, 3'h0, c));
		ex(imm(MOD_SYS, 3'h6, b));
		mem_rd_data = 16'($random(seed));
		ex(rs(4'h1, 3'h0, 4'h1, MOD_INDIR));
		chk("reg_wr.data", mem_rd_data, reg_wr.data);
		chk("stack_pointer_reg", {c, b} - 16'h0001, stack_pointer_reg);
		$display("pointer test done");
	endtask

	task automatic tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		rst = 1'b1;
		{instr_valid, instr, ext_src_data, mem_rd_data} = '0;
		{ext_src_wide, ext_dst_wide, irq_pending} = 3'b010;
		repeat (3) @(negedge clk_sys);
		rst = 1'b0;
		chk("prefix_data", 16'h0000, prefix_data);
		chk("general", 16'h0000, general_byte_register);
		for (int r = 0; r < 8; r++)
		begin
			hi = (r == 0) ? 8'hFF : 8'($random(seed));
			lo = (r == 0) ? 8'h80 : 8'($random(seed));
			b = 8'($random(seed));
			c = (r == 1) ? 8'hFF : 8'($random(seed));
			n = (r == 0) ? 3'h7 : 3'($random(seed));
			sub = (r == 1) ? 3'h7 : 3'($random(seed));
			s = r[0];
			t_prefix;
			t_sizes;
			t_branch;
			t_general;
			t_bitop;
			t_pointer;
		end
		tally_and_finish;
	end

	// eight rounds take 248 cycles after reset; allow over eight times that
	initial
	begin
		#(20 * 2000);
		n_fail++;
		tally_and_finish;
	end
endmodule
